/* hw/spm_port_mac_defines.vh */
// constants shared by the switch port mac
`ifndef SPM_PORT_MAC_DEFINES_VH
`define SPM_PORT_MAC_DEFINES_VH
// ************
// line interface modes
// ************
`define SPM_MODE_MII 3'h0
`define SPM_MODE_RMII 3'h1
`define SPM_MODE_REVMII 3'h2
`define SPM_MODE_SERIAL 3'h3
`define SPM_MODE_REVSERIAL 3'h4
`define SPM_MODE_GMII 3'h5
// ************
// speeds
// ************
`define SPM_SPD_10 2'h0
`define SPM_SPD_100 2'h1
`define SPM_SPD_1G 2'h2
// ************
// port numbers and phy addresses
// ************
`define SPM_HOST_PORT 4'h8
`define SPM_GIG_PORT 4'h9
`define SPM_PHY_BASE 5'h08
`define SPM_PHY_GIG 5'h10
// ************
// frame constants
// ************
`define SPM_MAX_ATTEMPTS 5'h10
`define SPM_PREAMBLE 8'h55
`define SPM_SFD 8'hD5
`define SPM_SFD_IDX 4'h7
`define SPM_JAM_TICKS 6'h20
`define SPM_GAP_TICKS 6'h18
`define SPM_SLOT_TICKS 8'h80
`define SPM_PAUSE_LEN 7'h3C
`define SPM_BYTE_BITS 4'h8
`define SPM_REV_DIV 2'h3
`define SPM_BACKOFF_CAP 3'h7
`endif

/* hw/spm_port_mac.v */
// one switch port mac: frame buffer, retry engine and line side
// Contract
// - line mac offers six interfaces, serial 10M only
// - half/full duplex with back pressure or flow control
// - collision retransmit, give up after 16 attempts
// - line port n phy at address 08h plus n
// - host port 8 sources clocks, no phy address
// - host port mii keeps duplex and throttling
// - gigabit port 9 forces full duplex at 1G
// - wrong phy address needs manual bring-up
// - frame accepted only once core scheduled it
// - power saving on inactivity, wake on activity
`include "spm_port_mac_defines.vh"
module spm_port_mac #(
  parameter PORT_NUM = 0,
  parameter DEPTH = 2048,
  parameter AW = 11,
  parameter IDLE_CYCLES = 20000,
  parameter [47:0] MAC_ADDR = 48'h020000000001
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // configuration
  input wire [2:0] ifMode,
  input wire [1:0] speed,
  input wire fullDuplex,
  input wire strapPowerSave,
  input wire manualUp,
  input wire phyLinkGood,
  input wire [4:0] phyRespAddr,
  // frame forwarding core, transmit side
  input wire txSched,
  input wire [7:0] txInByte,
  input wire txInValid,
  input wire txInLast,
  output wire txInReady,
  output reg txDone,
  output reg txDiscard,
  // frame forwarding core, receive side
  output reg [7:0] rxOutByte,
  output reg rxOutValid,
  output reg rxOutEnd,
  input wire bpReq,
  // line pins
  input wire lineClk,
  output reg lineClkOut,
  output reg [7:0] txd,
  output reg txEn,
  input wire [7:0] rxd,
  input wire rxDv,
  input wire col,
  input wire crs,
  // status
  output wire [4:0] phyAddr,
  output wire phyAddrValid,
  output wire linkUp,
  output wire modeErr,
  output reg lowPower,
  output reg [4:0] attempts
);
  // ************
  // states
  // ************
  localparam S_IDLE = 6'h01;
  localparam S_LOAD = 6'h02;
  localparam S_PRE = 6'h04;
  localparam S_DATA = 6'h08;
  localparam S_JAM = 6'h10;
  localparam S_WAIT = 6'h20;
  reg [5:0] state;
  reg [7:0] mem [0:DEPTH-1];
  reg [AW-1:0] idx;
  reg [AW-1:0] len;
  reg [3:0] subPos;
  reg [5:0] gapCnt;
  reg [15:0] waitCnt;
  reg [7:0] lfsr;
  reg isPause;
  reg isBp;
  reg pausePend;
  reg bpPrev;
  // ************
  // synchronisers: line pins cross two flops first
  // ************
  reg [1:0] clkSync;
  reg clkPrev;
  reg [7:0] rxdMeta, rxdSync;
  reg [3:0] ctlMeta, ctlSync;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clkSync <= 2'h0;
      clkPrev <= 1'b0;
      rxdMeta <= 8'h00;
      rxdSync <= 8'h00;
      ctlMeta <= 4'h0;
      ctlSync <= 4'h0;
    end else begin
      clkSync <= {clkSync[0], lineClk};
      clkPrev <= clkSync[1];
      rxdMeta <= rxd;
      rxdSync <= rxdMeta;
      ctlMeta <= {rxDv, col, crs, bpReq};
      ctlSync <= ctlMeta;
    end
  end
  wire rxDvS = ctlSync[3];
  wire colS = ctlSync[2];
  wire crsS = ctlSync[1];
  wire bpS = ctlSync[0];
  // ************
  // mode decode
  // ************
  wire serialMode = (ifMode == `SPM_MODE_SERIAL) ||
                    (ifMode == `SPM_MODE_REVSERIAL);
  wire revMode = serialMode ? (ifMode == `SPM_MODE_REVSERIAL) :
                 (ifMode == `SPM_MODE_REVMII);
  wire isGig = (PORT_NUM == `SPM_GIG_PORT);
  wire isHost = (PORT_NUM == `SPM_HOST_PORT);
  assign modeErr = (serialMode && speed != `SPM_SPD_10) ||
                   (isHost && ifMode != `SPM_MODE_REVMII) ||
                   (!isGig && ifMode == `SPM_MODE_GMII) ||
                   (isGig && ifMode != `SPM_MODE_GMII &&
                    ifMode != `SPM_MODE_MII);
  // 1G on the gigabit port never runs half duplex, whatever software asks
  wire fullDup = fullDuplex || (isGig && speed == `SPM_SPD_1G);
  reg [3:0] w;
  always @* begin
    case (ifMode)
      `SPM_MODE_RMII: w = 4'h2;
      `SPM_MODE_SERIAL, `SPM_MODE_REVSERIAL: w = 4'h1;
      `SPM_MODE_GMII: w = `SPM_BYTE_BITS;
      default: w = 4'h4;
    endcase
  end
  // ************
  // phy address and link bring-up
  // ************
  assign phyAddr = isGig ? `SPM_PHY_GIG :
                   (`SPM_PHY_BASE + PORT_NUM[4:0]);
  assign phyAddrValid = (PORT_NUM < `SPM_HOST_PORT) || isGig;
  // auto bring-up only when the phy answered at the expected address
  assign linkUp = !modeErr && (manualUp || (phyLinkGood &&
                  phyAddrValid && phyRespAddr == phyAddr));
  // ************
  // line tick: sampled clock edge, or own divider in reverse modes
  // ************
  reg [1:0] divCnt;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      divCnt <= 2'h0;
      lineClkOut <= 1'b0;
    end else begin
      divCnt <= divCnt + 2'h1;
      if (divCnt == `SPM_REV_DIV)
        lineClkOut <= !lineClkOut;
    end
  end
  wire divTick = (divCnt == `SPM_REV_DIV) && !lineClkOut;
  wire tick = revMode ? divTick : (clkSync[1] && !clkPrev);
  // ************
  // transmit byte source
  // ************
  function [7:0] pauseByte;
    input [AW-1:0] i;
    begin
      case (i[4:0])
        5'h00: pauseByte = 8'h01;
        5'h01: pauseByte = 8'h80;
        5'h02: pauseByte = 8'hC2;
        5'h05: pauseByte = 8'h01;
        5'h06: pauseByte = MAC_ADDR[47:40];
        5'h07: pauseByte = MAC_ADDR[39:32];
        5'h08: pauseByte = MAC_ADDR[31:24];
        5'h09: pauseByte = MAC_ADDR[23:16];
        5'h0A: pauseByte = MAC_ADDR[15:8];
        5'h0B: pauseByte = MAC_ADDR[7:0];
        5'h0C: pauseByte = 8'h88;
        5'h0D: pauseByte = 8'h08;
        5'h0F: pauseByte = 8'h01;
        5'h10, 5'h11: pauseByte = 8'hFF;
        default: pauseByte = 8'h00;
      endcase
      if (i > 5'h11)
        pauseByte = 8'h00;
    end
  endfunction
  reg [7:0] curByte;
  always @* begin
    if (state == S_PRE)
      curByte = (idx[3:0] == `SPM_SFD_IDX) ? `SPM_SFD : `SPM_PREAMBLE;
    else if (state == S_JAM)
      curByte = `SPM_PREAMBLE;
    else if (isPause)
      curByte = pauseByte(idx);
    else
      curByte = mem[idx];
  end
  wire [7:0] lineMask = (8'hFF >> (4'h8 - w));
  wire byteEnd = (subPos + w) == `SPM_BYTE_BITS;
  wire lastByte = (state == S_PRE) ? (idx[3:0] == `SPM_SFD_IDX) :
                  (idx == len - 1'b1);
  // only accepts bytes once the core has scheduled the frame
  assign txInReady = (state == S_LOAD) && txSched;
  // exponent stops at 7 instead of wrapping back to no backoff at all
  wire [2:0] backExp = (attempts > {2'h0, `SPM_BACKOFF_CAP}) ?
                       `SPM_BACKOFF_CAP : attempts[2:0];
  wire [15:0] backoff = {8'h00, lfsr & ~(8'hFF << backExp)} *
                        {8'h00, `SPM_SLOT_TICKS};
  // ************
  // transmit engine
  // ************
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_IDLE;
      idx <= {AW{1'b0}};
      len <= {AW{1'b0}};
      subPos <= 4'h0;
      gapCnt <= 6'h00;
      waitCnt <= 16'h0000;
      lfsr <= 8'h01;
      attempts <= 5'h00;
      isPause <= 1'b0;
      isBp <= 1'b0;
      pausePend <= 1'b0;
      bpPrev <= 1'b0;
      txd <= 8'h00;
      txEn <= 1'b0;
      txDone <= 1'b0;
      txDiscard <= 1'b0;
    end else begin
      txDone <= 1'b0;
      txDiscard <= 1'b0;
      lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      bpPrev <= bpS;
      // a new request wins over the clear of a pending pause
      if (bpS && !bpPrev && fullDup)
        pausePend <= 1'b1;
      else if (state == S_IDLE && pausePend && gapCnt == 6'h00 && tick)
        pausePend <= 1'b0;
      if (gapCnt != 6'h00 && tick)
        gapCnt <= gapCnt - 6'h01;
      case (state)
        S_IDLE: begin
          subPos <= 4'h0;
          idx <= {AW{1'b0}};
          if (gapCnt == 6'h00 && tick && linkUp) begin
            if (pausePend && fullDup) begin
              isPause <= 1'b1;
              len <= {{(AW-7){1'b0}}, `SPM_PAUSE_LEN};
              state <= S_PRE;
            end else if (bpS && crsS && !fullDup) begin
              isBp <= 1'b1;
              waitCnt <= {10'h000, `SPM_JAM_TICKS};
              state <= S_JAM;
            end else if (txSched) begin
              isPause <= 1'b0;
              state <= S_LOAD;
            end
          end
        end
        S_LOAD: begin
          if (txInValid && txSched) begin
            mem[idx] <= txInByte;
            idx <= idx + 1'b1;
            if (txInLast || idx == DEPTH - 1) begin
              len <= idx + 1'b1;
              attempts <= 5'h01;
              idx <= {AW{1'b0}};
              state <= S_WAIT;
              waitCnt <= 16'h0000;
            end
          end
        end
        S_PRE, S_DATA: begin
          if (!fullDup && colS) begin
            waitCnt <= {10'h000, `SPM_JAM_TICKS};
            state <= S_JAM;
          end else if (tick) begin
            txEn <= 1'b1;
            txd <= (curByte >> subPos) & lineMask;
            subPos <= byteEnd ? 4'h0 : subPos + w;
            if (byteEnd) begin
              idx <= lastByte ? {AW{1'b0}} : idx + 1'b1;
              if (lastByte && state == S_PRE)
                state <= S_DATA;
              else if (lastByte) begin
                state <= S_IDLE;
                gapCnt <= `SPM_GAP_TICKS;
                txDone <= !isPause;
                isPause <= 1'b0;
              end
            end
          end
        end
        S_JAM: begin
          if (tick) begin
            txEn <= 1'b1;
            txd <= `SPM_PREAMBLE & lineMask;
            waitCnt <= waitCnt - 16'h0001;
            if (waitCnt == 16'h0001) begin
              idx <= {AW{1'b0}};
              subPos <= 4'h0;
              if (isBp || isPause) begin
                isBp <= 1'b0;
                isPause <= 1'b0;
                gapCnt <= `SPM_GAP_TICKS;
                state <= S_IDLE;
              end else if (attempts == `SPM_MAX_ATTEMPTS) begin
                txDiscard <= 1'b1;
                gapCnt <= `SPM_GAP_TICKS;
                state <= S_IDLE;
              end else begin
                attempts <= attempts + 5'h01;
                waitCnt <= backoff;
                state <= S_WAIT;
              end
            end
          end
        end
        S_WAIT: begin
          // wait out backoff, then defer to carrier in half duplex
          if (tick && waitCnt != 16'h0000)
            waitCnt <= waitCnt - 16'h0001;
          else if (tick && (fullDup || !crsS))
            state <= S_PRE;
        end
        default: state <= S_IDLE;
      endcase
      // enable drops on a tick only, so the last nibble stands a full cycle
      if (tick && (state == S_IDLE || state == S_LOAD || state == S_WAIT))
        txEn <= 1'b0;
    end
  end
  // ************
  // receive: hunt start delimiter, then assemble bytes
  // ************
  reg [7:0] rxShift;
  reg [3:0] rxSub;
  reg rxInFrame;
  reg [7:0] nextShift;
  always @* begin
    case (w)
      4'h1: nextShift = {rxdSync[0], rxShift[7:1]};
      4'h2: nextShift = {rxdSync[1:0], rxShift[7:2]};
      4'h8: nextShift = rxdSync;
      default: nextShift = {rxdSync[3:0], rxShift[7:4]};
    endcase
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxShift <= 8'h00;
      rxSub <= 4'h0;
      rxInFrame <= 1'b0;
      rxOutByte <= 8'h00;
      rxOutValid <= 1'b0;
      rxOutEnd <= 1'b0;
    end else begin
      rxOutValid <= 1'b0;
      rxOutEnd <= 1'b0;
      if (tick) begin
        if (!rxDvS) begin
          rxOutEnd <= rxInFrame;
          rxInFrame <= 1'b0;
          rxShift <= 8'h00;
          rxSub <= 4'h0;
        end else begin
          rxShift <= nextShift;
          if (!rxInFrame) begin
            rxInFrame <= (nextShift == `SPM_SFD);
            rxSub <= 4'h0;
          end else if ((rxSub + w) == `SPM_BYTE_BITS) begin
            rxSub <= 4'h0;
            rxOutByte <= nextShift;
            rxOutValid <= 1'b1;
          end else
            rxSub <= rxSub + w;
        end
      end
    end
  end
  // ************
  // power saving: strap caught after reset release
  // ************
  reg strapTaken;
  reg saveEn;
  reg [31:0] idleCnt;
  wire active = txEn || rxDvS || crsS || txSched;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strapTaken <= 1'b0;
      saveEn <= 1'b0;
      idleCnt <= 32'h00000000;
      lowPower <= 1'b0;
    end else begin
      strapTaken <= 1'b1;
      if (!strapTaken)
        saveEn <= strapPowerSave;
      // leaves at once when activity shows again
      if (active || !saveEn) begin
        idleCnt <= 32'h00000000;
        lowPower <= 1'b0;
      end else if (idleCnt == IDLE_CYCLES - 1)
        lowPower <= 1'b1;
      else
        idleCnt <= idleCnt + 32'h00000001;
    end
  end
endmodule // spm_port_mac

/* bench/spm_port_mac_monitor.sv */
// checker for the switch port mac ports
module spm_port_mac_monitor #(
  parameter PORT_NUM = 0
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // configuration
  input wire [2:0] ifMode,
  input wire [1:0] speed,
  input wire manualUp,
  input wire phyLinkGood,
  input wire [4:0] phyRespAddr,
  // frame side
  input wire txSched,
  input wire txInReady,
  input wire txDone,
  input wire txDiscard,
  input wire rxOutEnd,
  // status
  input wire [4:0] phyAddr,
  input wire phyAddrValid,
  input wire linkUp,
  input wire modeErr,
  input wire [4:0] attempts
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ************
  // properties
  // ************
  property p_addr;
    phyAddrValid |->
      phyAddr == (PORT_NUM == 9 ? 5'h10 : 5'(8 + PORT_NUM));
  endproperty
  a_addr: assert property (p_addr)
    else $error("phy address wrong");
  property p_valid;
    phyAddrValid == (PORT_NUM != 8);
  endproperty
  a_valid: assert property (p_valid)
    else $error("phy address valid wrong");
  property p_link;
    linkUp == (!modeErr && (manualUp || phyLinkGood && phyAddrValid
      && phyRespAddr == phyAddr));
  endproperty
  a_link: assert property (p_link)
    else $error("link up wrong");
  property p_serial;
    (ifMode == 3'h3 || ifMode == 3'h4) && speed != 2'h0 |-> modeErr;
  endproperty
  a_serial: assert property (p_serial)
    else $error("serial above 10M allowed");
  property p_gmii;
    ifMode == 3'h5 && PORT_NUM != 9 |-> modeErr;
  endproperty
  a_gmii: assert property (p_gmii)
    else $error("gmii off gigabit port allowed");
  property p_ready;
    txInReady |-> txSched;
  endproperty
  a_ready: assert property (p_ready)
    else $error("ready without schedule");
  property p_cnt;
    attempts <= 5'h10;
  endproperty
  a_cnt: assert property (p_cnt)
    else $error("attempt count above limit");
  property p_drop;
    txDiscard |-> $past(attempts) == 5'h10;
  endproperty
  a_drop: assert property (p_drop)
    else $error("discard before last attempt");
  property p_pulse;
    txDone |=> !txDone && !txDiscard;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("done not a pulse");
  c_done: cover property (txDone);
  c_rx: cover property (rxOutEnd);
  c_retry: cover property (attempts == 5'h02);
endmodule // spm_port_mac_monitor
bind spm_port_mac spm_port_mac_monitor #(.PORT_NUM(PORT_NUM)) mon (
  .clk(clk), .rst_n(rst_n), .ifMode(ifMode), .speed(speed),
  .manualUp(manualUp), .phyLinkGood(phyLinkGood),
  .phyRespAddr(phyRespAddr), .txSched(txSched), .txInReady(txInReady),
  .txDone(txDone), .txDiscard(txDiscard), .rxOutEnd(rxOutEnd),
  .phyAddr(phyAddr), .phyAddrValid(phyAddrValid), .linkUp(linkUp),
  .modeErr(modeErr), .attempts(attempts));

/* bench/spm_phy_model.sv */
// behavioural mii phy facing the port mac
module spm_phy_model (
  // line pins
  output logic lineClk,
  input wire [7:0] txd,
  input wire txEn,
  output logic [7:0] rxd,
  output logic rxDv,
  output logic col,
  output logic crs,
  // bench command
  input wire colOn
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] sh = 8'h00;
  logic hunt = 1'b1;
  logic half = 1'b0;
  logic prevEn = 1'b0;
  logic [7:0] got[$];
  // mii clock from a phy runs free, the mac needs ticks when idle
  initial begin
    lineClk = 0;
    rxd = 8'hFF;
    rxDv = 0;
    forever #200 lineClk = ~lineClk;
  end
  // collision only while the mac transmits, carrier on either way
  assign col = colOn && txEn;
  assign crs = txEn || rxDv;
  // low nibble first; sampled on the falling edge, away from changes
  always @(negedge lineClk) begin
    if (txEn && !prevEn) got.delete();
    prevEn = txEn;
    if (!txEn) begin
      hunt = 1;
      half = 0;
    end else if (hunt) begin
      if ({txd[3:0], sh[7:4]} == 8'hD5) hunt = 0;
    end else begin
      if (half) got.push_back({txd[3:0], sh[7:4]});
      half = !half;
    end
    sh = {txd[3:0], sh[7:4]};
  end
  task rxByte(input logic [7:0] b);
    @(negedge lineClk);
    rxDv = 1;
    rxd = {4'h0, b[3:0]};
    @(negedge lineClk);
    rxd = {4'h0, b[7:4]};
  endtask
  // released data lines show the inverse, never the last value
  task rxEnd;
    @(negedge lineClk);
    rxDv = 0;
    rxd = ~rxd;
  endtask
endmodule // spm_phy_model

/* bench/spm_port_mac_tb.sv */
// self-checking bench for the switch port mac
`include "spm_port_mac_defines.vh"
`define CHK(n, e, g) begin cmpCount++; if ((g) !== (e)) begin badCount++;\
 $display("wrong value %s exp %h got %h", n, e, g); end end
module spm_port_mac_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, rst_n = 0, fullDuplex = 1, strapPowerSave = 0;
  logic manualUp = 0, phyLinkGood = 1, txSched = 0, txInValid = 0;
  logic txInLast = 0, bpReq = 0, colOn = 0, sawDone = 0, sawTx = 0;
  logic sawEnd = 0, sawDisc = 0, lastOut = 0;
  logic [2:0] ifMode = `SPM_MODE_MII;
  logic [1:0] speed = `SPM_SPD_100;
  logic [4:0] phyRespAddr = 5'h0B;
  logic [7:0] txInByte = 8'h00;
  wire txInReady, txDone, txDiscard, rxOutValid, rxOutEnd, lineClk;
  wire txEn, rxDv, col, crs, phyAddrValid, linkUp, modeErr, lowPower;
  wire [7:0] rxOutByte, txd, rxd;
  wire [4:0] phyAddr, attempts;
  wire clkOut;
  int badCount = 0, cmpCount = 0, k;
  logic [7:0] rq[$];
  logic [7:0] pay[4] = '{8'hA5, 8'h3C, 8'h00, 8'hFF};
  logic [7:0] hdr[6] = '{8'h01, 8'h80, 8'hC2, 8'h00, 8'h00, 8'h01};
  initial forever #25 clk = ~clk;
  spm_port_mac #(.PORT_NUM(3), .IDLE_CYCLES(50)) dut (
    .clk(clk), .rst_n(rst_n), .ifMode(ifMode), .speed(speed),
    .fullDuplex(fullDuplex), .strapPowerSave(strapPowerSave),
    .manualUp(manualUp), .phyLinkGood(phyLinkGood),
    .phyRespAddr(phyRespAddr), .txSched(txSched), .txInByte(txInByte),
    .txInValid(txInValid), .txInLast(txInLast), .txInReady(txInReady),
    .txDone(txDone), .txDiscard(txDiscard), .rxOutByte(rxOutByte),
    .rxOutValid(rxOutValid), .rxOutEnd(rxOutEnd), .bpReq(bpReq),
    .lineClk(lineClk), .lineClkOut(clkOut), .txd(txd), .txEn(txEn),
    .rxd(rxd),
    .rxDv(rxDv), .col(col), .crs(crs), .phyAddr(phyAddr),
    .phyAddrValid(phyAddrValid), .linkUp(linkUp), .modeErr(modeErr),
    .lowPower(lowPower), .attempts(attempts));
  spm_phy_model phy (.lineClk(lineClk), .txd(txd), .txEn(txEn),
    .rxd(rxd), .rxDv(rxDv), .col(col), .crs(crs), .colOn(colOn));
  always @(posedge clk) begin
    if (rxOutValid) rq.push_back(rxOutByte);
    if (txDone) sawDone = 1;
    if (txEn) sawTx = 1;
    if (rxOutEnd) sawEnd = 1;
    if (txDiscard) sawDisc = 1;
  end
  // ************
  // helpers
  // ************
  task step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task sendFrame;
    txSched = 1;
    for (int i = 0; i < 4; i++) begin
      txInByte = pay[i];
      txInValid = 1;
      txInLast = (i == 3);
      for (k = 0; k < 4000 && txInReady !== 1'b1; k++) step(1);
      step(1);
    end
    txInValid = 0;
    txInLast = 0;
    txSched = 0;
  endtask
  task waitDone(input int n);
    for (k = 0; k < n && !sawDone; k++) step(1);
  endtask
  task rxFrame;
    repeat (7) phy.rxByte(8'h55);
    phy.rxByte(8'hD5);
    foreach (pay[i]) phy.rxByte(pay[i]);
    phy.rxEnd;
    step(10);
  endtask
  task endOfTest;
    if (badCount == 0 && cmpCount > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ************
  // scenarios
  // ************
  task checkAddr;
    `CHK("phyAddr", 5'h0B, phyAddr)
    `CHK("phyAddrValid", 1'b1, phyAddrValid)
    lastOut = clkOut;
    step(4);
    `CHK("lineClkOut", !lastOut, clkOut)
    phyRespAddr = 5'h0C;
    step(1);
    `CHK("linkUp wrong addr", 1'b0, linkUp)
    manualUp = 1;
    step(1);
    `CHK("linkUp manual", 1'b1, linkUp)
    manualUp = 0;
    phyRespAddr = 5'h0B;
    for (int m = 0; m < 6; m++) begin
      ifMode = m[2:0];
      step(1);
      `CHK("modeErr 100M", m >= 3, modeErr)
    end
    speed = `SPM_SPD_10;
    for (int m = 3; m < 5; m++) begin
      ifMode = m[2:0];
      step(1);
      `CHK("modeErr 10M", 1'b0, modeErr)
    end
    ifMode = `SPM_MODE_MII;
    speed = `SPM_SPD_100;
    step(2);
    `CHK("linkUp", 1'b1, linkUp)
  endtask
  task checkGot;
    // the partner samples the last nibble a little after done shows
    step(10);
    `CHK("txSize", 4, phy.got.size())
    foreach (pay[i]) `CHK("txByte", pay[i], phy.got[i])
  endtask
  task checkTx;
    `CHK("ready unscheduled", 1'b0, txInReady)
    sawDone = 0;
    sendFrame;
    waitDone(2000);
    `CHK("txDone", 1'b1, sawDone)
    checkGot;
  endtask
  task checkRetry;
    fullDuplex = 0;
    colOn = 1;
    sawDone = 0;
    sawDisc = 0;
    sendFrame;
    for (k = 0; k < 4000 && attempts !== 5'h02; k++) step(1);
    colOn = 0;
    waitDone(4000);
    `CHK("retry done", 1'b1, sawDone)
    `CHK("attempts", 5'h02, attempts)
    `CHK("no discard", 1'b0, sawDisc)
    checkGot;
  endtask
  task checkRx;
    bpReq = 1;
    sawTx = 0;
    sawEnd = 0;
    rq.delete();
    rxFrame;
    `CHK("rxEnd", 1'b1, sawEnd)
    `CHK("rxSize", 4, rq.size())
    foreach (pay[i]) `CHK("rxByte", pay[i], rq[i])
    `CHK("back pressure jam", 1'b1, sawTx)
    bpReq = 0;
    fullDuplex = 1;
    // a back-pressure jam may still be running; let it and its gap end
    for (k = 0; k < 1000 && txEn !== 1'b0; k++) step(1);
    step(200);
  endtask
  task checkPause;
    sawDone = 0;
    bpReq = 1;
    for (k = 0; k < 500 && txEn !== 1'b1; k++) step(1);
    for (k = 0; k < 3000 && txEn !== 1'b0; k++) step(1);
    step(20);
    `CHK("pauseSize", 60, phy.got.size())
    foreach (hdr[i]) `CHK("pauseByte", hdr[i], phy.got[i])
    `CHK("pause no done", 1'b0, sawDone)
    bpReq = 0;
  endtask
  task checkPower;
    rst_n = 0;
    strapPowerSave = 1;
    step(4);
    rst_n = 1;
    for (k = 0; k < 500 && lowPower !== 1'b1; k++) step(1);
    `CHK("lowPower idle", 1'b1, lowPower)
    phy.rxByte(8'h55);
    step(4);
    `CHK("lowPower wake", 1'b0, lowPower)
    phy.rxEnd;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    #2 rst_n = 1;
    step(2);
    checkAddr;
    checkTx;
    checkRetry;
    checkRx;
    checkPause;
    checkPower;
    endOfTest;
  end
  // the longest path is one retry with full backoff
  initial begin
    repeat (40000) @(posedge clk);
    badCount++;
    endOfTest;
  end
endmodule // spm_port_mac_tb
